// ==== hdl/rdc_regs.sv ====
`timescale 1ns/1ns
module rdc_regs
  import rdc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int ECO_CYCLES = ECO_INTERVAL_CYCLES,
  parameter int FAST_CYCLES = FAST_INTERVAL_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_one,
  input wire logic pin_two,
  input wire logic pin_thirteen,
  input wire logic seq_slot_a,
  input wire logic seq_slot_b,
  output logic aux_a_on,
  output logic aux_a_voltage_b,
  output logic aux_a_pulldown,
  output logic aux_b_on,
  output logic aux_b_voltage_b,
  output logic aux_b_pulldown,
  output logic [VIB_W-1:0] vibration_level_code,
  output logic vibration_brake,
  output logic dvs_linear_choice,
  output logic peripheral_buck_choice,
  output logic memory_buck_choice,
  output logic processor_buck_choice,
  output logic core_buck_two_choice,
  output logic core_buck_one_choice,
  output logic io_buck_choice,
  output logic fast_interval,
  output logic auto_measure_tick,
  output logic convert_request,
  output logic [3:0] manual_input_selector,
  input wire logic convert_done,
  input wire logic [RES_W-1:0] convert_result
);
  typedef enum logic {MAN_IDLE, MAN_BUSY} rdc_man_state_t;
  localparam int TICK_W = $clog2(ECO_CYCLES + 1);
  localparam logic [TICK_W-1:0] ECO_RELOAD = TICK_W'(ECO_CYCLES - 1);
  localparam logic [TICK_W-1:0] FAST_RELOAD = TICK_W'(FAST_CYCLES - 1);

  // write channel holding registers
  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic rd_fire;

  // register contents
  logic [7:0] aux_a_ctrl;
  logic [7:0] aux_b_ctrl;
  logic [7:0] vibration_level;
  logic [7:0] vsel_one;
  logic [7:0] vsel_two;
  logic [7:0] man_cfg;
  logic [RES_W-1:0] result;
  rdc_man_state_t man_state;
  rdc_man_state_t next_man_state;
  logic man_write;
  logic man_start_req;
  logic [TICK_W-1:0] tick_count;

  rdc_pin_if pins ();

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_AUX_A && idx <= IDX_MAN_CTRL) || idx == IDX_RES_LOW
      || idx == IDX_RES_HIGH;
  endfunction

  function automatic logic [7:0] read_byte(input logic [IDX_W-1:0] idx);
    logic [7:0] r;
    r = 8'h00;
    if (idx == IDX_AUX_A) begin
      r = aux_a_ctrl;
    end else if (idx == IDX_AUX_B) begin
      r = aux_b_ctrl;
    end else if (idx == IDX_VIB) begin
      r = vibration_level;
    end else if (idx == IDX_VSEL_ONE) begin
      r = vsel_one;
    end else if (idx == IDX_VSEL_TWO) begin
      r = vsel_two;
    end else if (idx == IDX_MAN_CTRL) begin
      r = man_cfg;
      r[BIT_MAN_START] = (man_state == MAN_BUSY);
    end else if (idx == IDX_RES_LOW) begin
      r[RES_LSB_HI:RES_LSB_LO] = result[1:0];
    end else if (idx == IDX_RES_HIGH) begin
      r = result[RES_W-1:2];
    end
    return r;
  endfunction

  // write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= idx_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, read_byte(s_axi_araddr[ADDR_W-1:2])};
      s_axi_rresp <= idx_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pins and the two auxiliary regulators
  rdc_pin_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw({pin_thirteen, pin_two, pin_one}),
    .pins(pins.drive)
  );

  rdc_aux_linear u_aux_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_fire && w_lane0 && aw_idx == IDX_AUX_A),
    .wr_data(w_byte),
    .seq_slot(seq_slot_a),
    .pins(pins.use_side),
    .ctrl(aux_a_ctrl)
  );

  rdc_aux_linear u_aux_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_fire && w_lane0 && aw_idx == IDX_AUX_B),
    .wr_data(w_byte),
    .seq_slot(seq_slot_b),
    .pins(pins.use_side),
    .ctrl(aux_b_ctrl)
  );

  assign aux_a_on = aux_a_ctrl[BIT_ON];
  assign aux_a_voltage_b = aux_a_ctrl[BIT_VSEL];
  assign aux_a_pulldown = !aux_a_ctrl[BIT_ON] && !aux_a_ctrl[BIT_PD_DIS];
  assign aux_b_on = aux_b_ctrl[BIT_ON];
  assign aux_b_voltage_b = aux_b_ctrl[BIT_VSEL];
  assign aux_b_pulldown = !aux_b_ctrl[BIT_ON] && !aux_b_ctrl[BIT_PD_DIS];

  // vibration level and ramped voltage choices
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vibration_level <= VIB_RESET;
      vsel_one <= VSEL_RESET;
      vsel_two <= VSEL_RESET;
    end else if (wr_fire && w_lane0) begin
      if (aw_idx == IDX_VIB) begin
        vibration_level <= w_byte & VIB_MASK;
      end
      if (aw_idx == IDX_VSEL_ONE) begin
        vsel_one <= w_byte & VSEL_ONE_MASK;
      end
      if (aw_idx == IDX_VSEL_TWO) begin
        vsel_two <= w_byte & VSEL_TWO_MASK;
      end
    end
  end

  assign vibration_level_code = vibration_level[VIB_W-1:0];
  assign vibration_brake = vibration_level[VIB_W-1:0] == VIB_BRAKE_CODE;
  assign dvs_linear_choice = vsel_one[BIT_DVS_LINEAR];
  assign peripheral_buck_choice = vsel_one[BIT_PERI_BUCK];
  assign memory_buck_choice = vsel_one[BIT_MEM_BUCK];
  assign processor_buck_choice = vsel_one[BIT_PROC_BUCK];
  assign core_buck_two_choice = vsel_one[BIT_CORE_TWO];
  assign core_buck_one_choice = vsel_one[BIT_CORE_ONE];
  assign io_buck_choice = vsel_two[BIT_IO_BUCK];

  // converter manual control: interval and selector
  assign man_write = wr_fire && w_lane0 && aw_idx == IDX_MAN_CTRL;
  assign man_start_req = man_write && w_byte[BIT_MAN_START] && mux_legal(w_byte[MUX_HI:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      man_cfg <= MAN_RESET;
    end else if (man_write) begin
      man_cfg <= w_byte & MAN_MASK;
    end
  end

  assign fast_interval = man_cfg[BIT_FAST_INTERVAL];
  assign manual_input_selector = man_cfg[MUX_HI:0];

  // start bit is the busy state; a new start wins over completion
  always_comb begin
    next_man_state = man_state;
    unique case (man_state)
      MAN_IDLE: begin
        if (man_start_req) begin
          next_man_state = MAN_BUSY;
        end
      end
      MAN_BUSY: begin
        if (convert_done && !man_start_req) begin
          next_man_state = MAN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      man_state <= MAN_IDLE;
    end else begin
      man_state <= next_man_state;
    end
  end

  assign convert_request = man_state == MAN_BUSY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= RESULT_RESET;
    end else if (man_state == MAN_BUSY && convert_done) begin
      result <= convert_result;
    end
  end

  // automatic measurement interval tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= ECO_RELOAD;
      auto_measure_tick <= 1'b0;
    end else if (tick_count == '0) begin
      tick_count <= fast_interval ? FAST_RELOAD : ECO_RELOAD;
      auto_measure_tick <= 1'b1;
    end else begin
      if (fast_interval && tick_count > FAST_RELOAD) begin
        tick_count <= FAST_RELOAD;
      end else begin
        tick_count <= tick_count - 1'b1;
      end
      auto_measure_tick <= 1'b0;
    end
  end
endmodule

// ==== common/rdc_pkg.sv ====
package rdc_pkg;

  // clock and automatic measurement timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int ECO_INTERVAL_MS = 10;
  localparam int FAST_INTERVAL_MS = 1;
  localparam int ECO_INTERVAL_CYCLES = ECO_INTERVAL_MS * CYCLES_PER_MS;
  localparam int FAST_INTERVAL_CYCLES = FAST_INTERVAL_MS * CYCLES_PER_MS;

  // register indices; byte address is four times the index
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_AUX_A = 6'h2E;
  localparam logic [IDX_W-1:0] IDX_RSVD_2F = 6'h2F;
  localparam logic [IDX_W-1:0] IDX_AUX_B = 6'h30;
  localparam logic [IDX_W-1:0] IDX_VIB = 6'h31;
  localparam logic [IDX_W-1:0] IDX_VSEL_ONE = 6'h32;
  localparam logic [IDX_W-1:0] IDX_VSEL_TWO = 6'h33;
  localparam logic [IDX_W-1:0] IDX_MAN_CTRL = 6'h34;
  localparam logic [IDX_W-1:0] IDX_RES_LOW = 6'h37;
  localparam logic [IDX_W-1:0] IDX_RES_HIGH = 6'h38;

  // reset values
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] VIB_RESET = 8'h00;
  localparam logic [7:0] VSEL_RESET = 8'h00;
  localparam logic [7:0] MAN_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // auxiliary linear regulator control fields
  localparam int BIT_SEQ_TARGET = 7;
  localparam int VPIN_HI = 6;
  localparam int VPIN_LO = 5;
  localparam int BIT_VSEL = 4;
  localparam int BIT_PD_DIS = 3;
  localparam int EPIN_HI = 2;
  localparam int EPIN_LO = 1;
  localparam int BIT_ON = 0;

  // writable bit masks, reserved bits read zero
  localparam logic [7:0] VIB_MASK = 8'h3F;
  localparam logic [7:0] VSEL_ONE_MASK = 8'h9F;
  localparam logic [7:0] VSEL_TWO_MASK = 8'h01;
  localparam logic [7:0] MAN_MASK = 8'h2F;

  localparam int VIB_W = 6;
  localparam logic [VIB_W-1:0] VIB_BRAKE_CODE = 6'h00;

  localparam int BIT_DVS_LINEAR = 7;
  localparam int BIT_PERI_BUCK = 4;
  localparam int BIT_MEM_BUCK = 3;
  localparam int BIT_PROC_BUCK = 2;
  localparam int BIT_CORE_TWO = 1;
  localparam int BIT_CORE_ONE = 0;
  localparam int BIT_IO_BUCK = 0;

  // converter manual control fields
  localparam int BIT_FAST_INTERVAL = 5;
  localparam int BIT_MAN_START = 4;
  localparam int MUX_HI = 3;
  localparam int RES_W = 10;
  localparam int RES_LSB_HI = 7;
  localparam int RES_LSB_LO = 6;
  localparam logic [3:0] MUX_LAST_INPUT = 4'h4;
  localparam logic [3:0] MUX_FIRST_GROUP = 4'h8;
  localparam logic [3:0] MUX_LAST_GROUP = 4'hA;

  localparam int PIN_COUNT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIN_NONE = 2'h0,
    PIN_ONE = 2'h1,
    PIN_TWO = 2'h2,
    PIN_THIRTEEN = 2'h3
  } rdc_pin_sel_t;

  // event of the selected pin; no pin selected gives no event
  function automatic logic pin_pick(input logic [1:0] sel, input logic [PIN_COUNT-1:0] ev);
    logic r;
    r = 1'b0;
    unique case (rdc_pin_sel_t'(sel))
      PIN_NONE: r = 1'b0;
      PIN_ONE: r = ev[0];
      PIN_TWO: r = ev[1];
      PIN_THIRTEEN: r = ev[2];
    endcase
    return r;
  endfunction

  function automatic logic mux_legal(input logic [3:0] code);
    return (code <= MUX_LAST_INPUT) || (code >= MUX_FIRST_GROUP && code <= MUX_LAST_GROUP);
  endfunction

endpackage

// ==== common/rdc_pin_if.sv ====
`timescale 1ns/1ns
interface rdc_pin_if;
  import rdc_pkg::*;
  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;
  modport drive (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

// ==== hdl/rdc_pin_sync.sv ====
`timescale 1ns/1ns
module rdc_pin_sync
  import rdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PIN_COUNT-1:0] pin_raw,
  rdc_pin_if.drive pins
);
  logic [PIN_COUNT-1:0] meta;
  logic [PIN_COUNT-1:0] stable;
  logic [PIN_COUNT-1:0] last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      stable <= '0;
      last <= '0;
    end else begin
      meta <= pin_raw;
      stable <= meta;
      last <= stable;
    end
  end

  assign pins.level = stable;
  assign pins.rise = stable & ~last;
  assign pins.fall = ~stable & last;
endmodule

// ==== hdl/rdc_aux_linear.sv ====
`timescale 1ns/1ns
module rdc_aux_linear
  import rdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic seq_slot,
  rdc_pin_if.use_side pins,
  output logic [7:0] ctrl
);
  logic seq_target;
  logic [1:0] vpin;
  logic vsel;
  logic pd_dis;
  logic [1:0] epin;
  logic on;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_target <= AUX_RESET[BIT_SEQ_TARGET];
      vpin <= AUX_RESET[VPIN_HI:VPIN_LO];
      pd_dis <= AUX_RESET[BIT_PD_DIS];
      epin <= AUX_RESET[EPIN_HI:EPIN_LO];
    end else if (wr_en) begin
      seq_target <= wr_data[BIT_SEQ_TARGET];
      vpin <= wr_data[VPIN_HI:VPIN_LO];
      pd_dis <= wr_data[BIT_PD_DIS];
      epin <= wr_data[EPIN_HI:EPIN_LO];
    end
  end

  // voltage choice: software write, then pin edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vsel <= AUX_RESET[BIT_VSEL];
    end else if (wr_en) begin
      vsel <= wr_data[BIT_VSEL];
    end else if (pin_pick(vpin, pins.rise)) begin
      vsel <= 1'b0;
    end else if (pin_pick(vpin, pins.fall)) begin
      vsel <= 1'b1;
    end
  end

  // enable: software write, then pin edge, then sequencer slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on <= AUX_RESET[BIT_ON];
    end else if (wr_en) begin
      on <= wr_data[BIT_ON];
    end else if (pin_pick(epin, pins.rise)) begin
      on <= 1'b1;
    end else if (pin_pick(epin, pins.fall)) begin
      on <= 1'b0;
    end else if (seq_slot && epin == PIN_NONE) begin
      on <= seq_target;
    end
  end

  assign ctrl = {seq_target, vpin, vsel, pd_dis, epin, on};
endmodule

// ==== testbench/rdc_regs_props.sv ====
`timescale 1ns/1ns
module rdc_regs_props
  import rdc_pkg::*;
#(
  parameter int ECO_CYCLES = 40,
  parameter int FAST_CYCLES = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic aux_a_on,
  input wire logic aux_a_pulldown,
  input wire logic aux_b_on,
  input wire logic aux_b_pulldown,
  input wire logic [VIB_W-1:0] vibration_level_code,
  input wire logic vibration_brake,
  input wire logic fast_interval,
  input wire logic auto_measure_tick,
  input wire logic convert_request,
  input wire logic convert_done
);
  int gap;
  logic seen, run_fast, run_eco, fast_q;
  // cycles since the last tick, and whether the mode held all along
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 0;
      seen <= 1'h0;
      run_fast <= 1'h0;
      run_eco <= 1'h0;
    end else if (auto_measure_tick) begin
      gap <= 0;
      seen <= 1'h1;
      run_fast <= fast_interval && fast_q;
      run_eco <= !fast_interval && !fast_q;
    end else begin
      gap <= gap + 1;
      run_fast <= run_fast && fast_interval;
      run_eco <= run_eco && !fast_interval;
    end
  end
  // mode one edge back: an interval reloaded just before a mode change is skipped
  always_ff @(posedge aclk) begin
    fast_q <= fast_interval;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pulldown;
    !(aux_a_on && aux_a_pulldown) && !(aux_b_on && aux_b_pulldown);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown while enabled");
  property p_brake;
    vibration_brake == (vibration_level_code == 6'h00);
  endproperty
  a_brake: assert property (p_brake) else $error("brake mismatch");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_done;
    convert_request && convert_done && s_axi_awready |=> !convert_request;
  endproperty
  a_done: assert property (p_done) else $error("start bit not cleared");
  property p_tick_fast;
    auto_measure_tick && seen && run_fast |-> gap == FAST_CYCLES - 1;
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast interval wrong");
  property p_tick_eco;
    auto_measure_tick && seen && run_eco |-> gap == ECO_CYCLES - 1;
  endproperty
  a_tick_eco: assert property (p_tick_eco) else $error("economy interval wrong");
  property p_reset;
    $rose(aresetn) |-> !aux_a_on && !aux_b_on && !convert_request && vibration_brake;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import rdc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic awready, wready, arready, slot_a, slot_b, done, tick, busy, fast;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] pin_lv;
  logic [9:0] result;
  logic a_on, a_vb, a_pd, b_on, b_vb, b_pd, brake, dvs, peri, mem, proc, core2, core1, io;
  logic [5:0] vibration_level;
  logic [3:0] mux, wstrb;
  int err_total, check_count;
  rdc_regs #(.ADDR_W(8), .ECO_CYCLES(40), .FAST_CYCLES(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_one(pin_lv[0]), .pin_two(pin_lv[1]), .pin_thirteen(pin_lv[2]),
    .seq_slot_a(slot_a), .seq_slot_b(slot_b), .aux_a_on(a_on), .aux_a_voltage_b(a_vb),
    .aux_a_pulldown(a_pd), .aux_b_on(b_on), .aux_b_voltage_b(b_vb), .aux_b_pulldown(b_pd),
    .vibration_level_code(vibration_level), .vibration_brake(brake), .dvs_linear_choice(dvs),
    .peripheral_buck_choice(peri), .memory_buck_choice(mem), .processor_buck_choice(proc),
    .core_buck_two_choice(core2), .core_buck_one_choice(core1), .io_buck_choice(io),
    .fast_interval(fast), .auto_measure_tick(tick), .convert_request(busy),
    .manual_input_selector(mux), .convert_done(done), .convert_result(result)
  );
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  task automatic complete_run;
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus transfer; ready is raised late so the answer has to wait
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d,
                      input logic [1:0] er);
    logic ok, ah, wh;
    logic [1:0] r;
    logic [31:0] q;
    int n;
    @(posedge aclk);
    if (w) begin
      awaddr <= {ix, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
    end else begin
      araddr <= {ix, 2'h0};
      arvalid <= 1'h1;
    end
    n = 0;
    ok = 1'h0;
    while (!ok) begin
      @(negedge aclk);
      ah = (awvalid && awready) || (arvalid && arready);
      wh = wvalid && wready;
      ok = w ? (bvalid && bready) : (rvalid && rready);
      r = w ? bresp : rresp;
      q = rdata;
      @(posedge aclk);
      n++;
      if (ah) begin
        awvalid <= 1'h0;
        arvalid <= 1'h0;
      end
      if (wh) wvalid <= 1'h0;
      if (n == 3) begin
        bready <= w;
        rready <= !w;
      end
    end
    bready <= 1'h0;
    rready <= 1'h0;
    @(negedge aclk);
    chk($sformatf("resp %h", ix), er, r);
    if (!w) chk($sformatf("rdata %h", ix), {24'h0, d}, q);
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge aclk);
    pin_lv[k] <= v;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic slot(input int r);
    @(posedge aclk);
    if (r) slot_b <= 1'h1;
    else slot_a <= 1'h1;
    @(posedge aclk);
    slot_a <= 1'h0;
    slot_b <= 1'h0;
    @(negedge aclk);
  endtask
  function automatic logic [2:0] aux(input int r);
    return r ? {b_on, b_vb, b_pd} : {a_on, a_vb, a_pd};
  endfunction
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end
  initial begin
    logic [5:0] ix;
    logic [7:0] v;
    logic lg;
    logic [9:0] res, keep;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slot_a, slot_b, done} = 9'h0;
    {awaddr, araddr, wdata, pin_lv, result} = '0;
    wstrb = 4'hF;
    err_total = 0;
    check_count = 0;
    keep = 10'h000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk("reset_out", 32'h7, {a_pd, b_pd, brake});
    for (int i = 8'h2E; i <= 8'h38; i++) begin
      xfer(0, i[5:0], 8'h00, (i == 8'h35 || i == 8'h36) ? RESP_SLVERR : RESP_OKAY);
    end
    xfer(1, IDX_RSVD_2F, 8'hFF, RESP_OKAY);
    xfer(0, IDX_RSVD_2F, 8'h00, RESP_OKAY);
    xfer(1, 6'h35, 8'hFF, RESP_SLVERR);
    for (int r = 0; r < 2; r++) begin
      ix = r ? IDX_AUX_B : IDX_AUX_A;
      xfer(1, ix, 8'h19, RESP_OKAY);
      chk("aux_write", 32'h6, aux(r));
      xfer(0, ix, 8'h19, RESP_OKAY);
      xfer(1, ix, 8'h08, RESP_OKAY);
      chk("aux_nopd", 32'h0, aux(r));
      xfer(1, ix, 8'h80, RESP_OKAY);
      chk("aux_pd", 32'h1, aux(r));
      slot(r);
      chk("aux_slot", 32'h4, aux(r));
      xfer(0, ix, 8'h81, RESP_OKAY);
      for (int p = 1; p < 4; p++) begin
        xfer(1, ix, {1'h0, p[1:0], 1'h1, 1'h0, p[1:0], 1'h0}, RESP_OKAY);
        pin(p - 1, 1'h1);
        chk("pin_rise", 32'h4, aux(r));
        xfer(0, ix, {1'h0, p[1:0], 1'h0, 1'h0, p[1:0], 1'h1}, RESP_OKAY);
        pin(p - 1, 1'h0);
        chk("pin_fall", 32'h3, aux(r));
      end
      xfer(1, ix, 8'h82, RESP_OKAY);
      slot(r);
      chk("slot_ignored", 32'h1, aux(r));
    end
    xfer(1, IDX_VIB, 8'hFF, RESP_OKAY);
    chk("vib_max", 32'h3F, {brake, vibration_level});
    xfer(0, IDX_VIB, 8'h3F, RESP_OKAY);
    xfer(1, IDX_VIB, 8'h00, RESP_OKAY);
    chk("vib_brake", 32'h40, {brake, vibration_level});
    // lane 0 strobe low: the write is answered but stores nothing
    @(posedge aclk);
    wstrb <= 4'hE;
    xfer(1, IDX_VIB, 8'h15, RESP_OKAY);
    chk("vib_lane", 32'h40, {brake, vibration_level});
    @(posedge aclk);
    wstrb <= 4'hF;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      xfer(1, IDX_VSEL_ONE, v, RESP_OKAY);
      chk("vsel", {v[7], v[4:0]}, {dvs, peri, mem, proc, core2, core1});
      xfer(0, IDX_VSEL_ONE, v & 8'h9F, RESP_OKAY);
      xfer(1, IDX_VSEL_TWO, v, RESP_OKAY);
      chk("io", v[0], io);
    end
    for (int c = 0; c < 16; c++) begin
      lg = (c <= 4) || (c >= 8 && c <= 10);
      res = {c[3:0], 2'h2, c[3:0]};
      xfer(1, IDX_MAN_CTRL, 8'h30 | c[7:0], RESP_OKAY);
      chk("busy", lg, busy);
      chk("mux_fast", {c[3:0], 1'h1}, {mux, fast});
      xfer(0, IDX_MAN_CTRL, {2'h0, 1'h1, lg, c[3:0]}, RESP_OKAY);
      @(posedge aclk);
      done <= 1'h1;
      result <= res;
      @(posedge aclk);
      done <= 1'h0;
      result <= ~res;
      @(negedge aclk);
      chk("busy_clear", 32'h0, busy);
      if (lg) keep = res;
      xfer(0, IDX_RES_LOW, {keep[1:0], 6'h00}, RESP_OKAY);
      xfer(0, IDX_RES_HIGH, keep[9:2], RESP_OKAY);
    end
    complete_run();
  end
endmodule
bind rdc_regs rdc_regs_props #(.ECO_CYCLES(ECO_CYCLES), .FAST_CYCLES(FAST_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .aux_a_on(aux_a_on), .aux_a_pulldown(aux_a_pulldown), .aux_b_on(aux_b_on),
  .aux_b_pulldown(aux_b_pulldown), .vibration_level_code(vibration_level_code),
  .vibration_brake(vibration_brake), .fast_interval(fast_interval),
  .auto_measure_tick(auto_measure_tick), .convert_request(convert_request),
  .convert_done(convert_done)
);
